// ### bus_cycle_if.sv
// request/answer wires between the sequencer and its bus cycle engine
`default_nettype none
interface bus_cycle_if;
  import nor_cmd_pkg::*;
  logic start;
  logic is_write;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic done;
  logic [DATA_W-1:0] rdata;
  modport seq(output start, output is_write, output addr, output wdata,
              input done, input rdata);
  modport eng(input start, input is_write, input addr, input wdata,
              output done, output rdata);
endinterface : bus_cycle_if
`default_nettype wire

// ### flash_model.sv
// behavioural parallel flash answering the sequencer's bus cycles
`default_nettype none
// ==========================================
// device model
module flash_model
  import nor_cmd_pkg::*;
#(
  parameter logic [7:0] PROT_SECTOR = 8'h03
) (
  input wire logic byte_mode_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic dq_oe_in,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] mem [int];
  bit [255:0] erased;
  bit armed, bypass, autosel, secured, erasing, suspended, timeout, query, chip;
  int st, n_writes;
  logic [ADDR_W-1:0] la;
  logic [DATA_W-1:0] last = '0;
  wire logic wr_n = ce_n_in | we_n_in;
  wire logic rd_n = ce_n_in | oe_n_in;
  function automatic void wipe(input logic [7:0] s);
    int k[$];
    foreach (mem[i]) if (i[19:12] == s) k.push_back(i);
    foreach (k[j]) mem.delete(k[j]);
    erased[s] = 1'b1;
  endfunction : wipe
  function automatic logic [DATA_W-1:0] rd_val(input logic [ADDR_W-1:0] a);
    if (autosel && a[11:0] == (byte_mode_in ? PROT_OFS_BYTE[11:0] : PROT_OFS_WORD[11:0]))
      return {15'h0000, a[19:12] == PROT_SECTOR};
    if (mem.exists(a)) return mem[a];
    return erased[a[19:12]] ? 16'hFFFF : a[15:0] ^ 16'h5A5A;
  endfunction : rd_val
  // released bus shows the inverse of the last value read
  always @* dq_out = (!ce_n_in && !oe_n_in) ? rd_val(addr_in) : ~last;
  always @(posedge rd_n) begin
    last = rd_val(addr_in);
    // erase is taken as finished by the first read while not suspended
    if (erasing && !suspended) begin
      erasing = 1'b0;
      chip = 1'b0;
    end
  end
  always @(negedge wr_n) begin
    la = addr_in;
    armed = 1'b1;
  end
  always @(posedge wr_n) begin : take_write
    logic [DATA_W-1:0] d;
    logic [7:0] c;
    logic [ADDR_W-1:0] m;
    logic u1, u2;
    if (armed) begin
      armed = 1'b0;
      n_writes++;
      d = dq_oe_in ? dq_in : 16'hBAD0;
      c = d[7:0];
      m = byte_mode_in ? 20'h00FFF : 20'h007FF;
      u1 = (la & m) == (byte_mode_in ? UNLOCK1_BYTE : UNLOCK1_WORD);
      u2 = (la & m) == (byte_mode_in ? UNLOCK2_BYTE : UNLOCK2_WORD);
      if (c != D_SECTOR_ERASE) timeout = 1'b0;
      case (st)
        0: begin
          if (c == D_RESET) begin
            bypass = 1'b0;
            autosel = 1'b0;
            query = 1'b0;
          end else if (bypass && c == D_PROGRAM) st = 7;
          else if (bypass && c == D_EXIT1) st = 8;
          else if (timeout && c == D_SECTOR_ERASE) wipe(la[19:12]);
          else if (c == D_SUSPEND && erasing && !chip) suspended = 1'b1;
          else if (c == D_RESUME && suspended) suspended = 1'b0;
          else if (c == D_QUERY && !bypass && !erasing &&
                   (la & m) == (byte_mode_in ? QUERY_BYTE : QUERY_WORD)) query = 1'b1;
          else if (c == D_UNLOCK1 && u1) st = 1;
        end
        1: st = (c == D_UNLOCK2 && u2) ? 2 : 0;
        2: begin
          st = 0;
          if (u1) begin
            case (c)
              D_PROGRAM: st = 3;
              D_ERASE_SETUP: st = 4;
              D_AUTOSELECT: if (secured) st = 9; else autosel = 1'b1;
              D_ID_ENTER: secured = 1'b1;
              D_BYPASS: bypass = 1'b1;
              default: st = 0;
            endcase
          end
        end
        3, 7: begin
          mem[la] = d;
          st = 0;
        end
        4: st = (c == D_UNLOCK1 && u1) ? 5 : 0;
        5: st = (c == D_UNLOCK2 && u2) ? 6 : 0;
        6: begin
          st = 0;
          if (c == D_CHIP_ERASE && u1) begin
            mem.delete();
            erased = '1;
            erasing = 1'b1;
            chip = 1'b1;
          end else if (c == D_SECTOR_ERASE) begin
            wipe(la[19:12]);
            erasing = 1'b1;
            timeout = 1'b1;
          end
        end
        8, 9: begin
          if (c == D_EXIT2 && st == 8) bypass = 1'b0;
          if (c == D_EXIT2 && st == 9) secured = 1'b0;
          st = 0;
        end
        default: st = 0;
      endcase
    end
  end
endmodule : flash_model
`default_nettype wire

// ### nor_bus_cycle.sv
// one asynchronous read or write cycle on the flash pins
`default_nettype none
module nor_bus_cycle
  import nor_cmd_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  bus_cycle_if.eng cyc,
  output logic [ADDR_W-1:0] addr_out,
  output logic ce_n_out,
  output logic we_n_out,
  output logic oe_n_out,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_out,
  input wire logic [DATA_W-1:0] dq_in
);
  import nor_cmd_pkg::*;
  typedef enum logic [2:0] {C_IDLE, C_SETUP, C_PULSE, C_HOLD, C_DONE} cyc_e;
  cyc_e st;
  logic [TMR_W-1:0] tmr;
  logic wr;
  // ======================================================
  // phase sequencing
  // address is stable before both strobes fall and data before both rise,
  // so the device's later-fall address latch and earlier-rise data latch
  // see settled values whichever strobe it keys on
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      st <= C_IDLE;
      tmr <= '0;
      wr <= 1'b0;
    end else begin
      case (st)
        C_IDLE: if (cyc.start) begin
          st <= C_SETUP;
          wr <= cyc.is_write;
          tmr <= TMR_W'(SETUP_CYC);
        end
        C_SETUP: if (tmr <= TMR_W'(1)) begin
          st <= C_PULSE;
          tmr <= wr ? TMR_W'(PULSE_CYC) : TMR_W'(ACCESS_CYC);
        end else tmr <= tmr - TMR_W'(1);
        C_PULSE: if (tmr <= TMR_W'(1)) begin
          st <= C_HOLD;
          tmr <= TMR_W'(HOLD_CYC);
        end else tmr <= tmr - TMR_W'(1);
        C_HOLD: if (tmr <= TMR_W'(1)) st <= C_DONE;
          else tmr <= tmr - TMR_W'(1);
        C_DONE: st <= C_IDLE;
        default: st <= C_IDLE;
      endcase
    end
  end
  // ======================================================
  // pins, all from flops
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      addr_out <= '0;
      dq_out <= '0;
      dq_oe_out <= 1'b0;
      ce_n_out <= 1'b1;
      we_n_out <= 1'b1;
      oe_n_out <= 1'b1;
      cyc.rdata <= '0;
    end else begin
      if (st == C_IDLE && cyc.start) begin
        addr_out <= cyc.addr;
        dq_out <= cyc.wdata;
        dq_oe_out <= cyc.is_write;
      end
      ce_n_out <= !(st == C_SETUP || st == C_PULSE);
      we_n_out <= !(wr && (st == C_SETUP || st == C_PULSE));
      oe_n_out <= !(!wr && (st == C_SETUP || st == C_PULSE));
      if (st == C_PULSE && !wr && tmr <= TMR_W'(1)) cyc.rdata <= dq_in;
      if (st == C_DONE) dq_oe_out <= 1'b0;
    end
  end
  assign cyc.done = (st == C_DONE);
endmodule : nor_bus_cycle
`default_nettype wire

// ### nor_cmd_host.sv
// host sequencer issuing command sequences to a parallel nor flash
`default_nettype none
// Summary of operation
// (R1) device latches address on later strobe fall
// (R2) device latches data on earlier strobe rise
// (R3) program: two unlocks, A0, then address/data
// (R4) sector chosen only by sector address bits
// (R5) all cycles write except read, ID fourth
// (R6) upper data byte ignored on command cycles
// (R7) upper address bits ignored except sector/program
// (R8) array reads need no command prefix
// (R9) reset returns from ID or timing error
// (R10) protect verify reads 00 or 01
// (R11) query only from array or ID mode
// (R12) bypass: enter with 20, program A0+data
// (R13) bypass exit 90 then 00, F0 too
// (R14) suspended erase allows reads, programs, ID
// (R15) suspend B0 only during sector erase
// (R16) resume 30 only while erase suspended
// (R17) extra sectors: one SA/30 write in time-out
// (R18) unlock addresses and data per bus width
// (R19) erase: six writes, 10 chip, 30 sector
// (R20) ID enter 88; exit unlock, 90, 00
// (R21) suspend takes effect within 35 us
// (R22) after resume, suspend accepted, resume ignored
module nor_cmd_host
  import nor_cmd_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic byte_mode_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire nor_cmd_pkg::op_e req_op_in,
  input wire logic [nor_cmd_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic [nor_cmd_pkg::DATA_W-1:0] req_data_in,
  output logic resp_valid_out,
  output logic [nor_cmd_pkg::DATA_W-1:0] resp_data_out,
  output logic req_refused_out,
  output logic bypass_mode_out,
  output logic id_mode_out,
  output logic erase_active_out,
  output logic erase_suspended_out,
  output logic [nor_cmd_pkg::ADDR_W-1:0] flash_addr_out,
  output logic flash_ce_n_out,
  output logic flash_we_n_out,
  output logic flash_oe_n_out,
  output logic [nor_cmd_pkg::DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_out,
  input wire logic [nor_cmd_pkg::DATA_W-1:0] flash_dq_in
);
  import nor_cmd_pkg::*;
  localparam int MAXSTEP = 6;
  typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT, H_RESP} host_e;
  host_e st;
  op_e op;
  logic [ADDR_W-1:0] tgt_addr;
  logic [DATA_W-1:0] tgt_data;
  logic [2:0] step;
  logic [2:0] nsteps;
  logic step_write;
  logic [ADDR_W-1:0] step_addr;
  logic [7:0] step_data;
  logic accept;
  logic legal;
  logic [ADDR_W-1:0] u1;
  logic [ADDR_W-1:0] u2;
  logic [ADDR_W-1:0] sec_addr;
  logic [ADDR_W-1:0] qry;
  logic [ADDR_W-1:0] prot_ofs;
  bus_cycle_if cyc();

  nor_bus_cycle u_cycle (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .cyc(cyc),
    .addr_out(flash_addr_out),
    .ce_n_out(flash_ce_n_out),
    .we_n_out(flash_we_n_out),
    .oe_n_out(flash_oe_n_out),
    .dq_out(flash_dq_out),
    .dq_oe_out(flash_dq_oe_out),
    .dq_in(flash_dq_in)
  );

  // ======================================================
  // address selection per bus width
  assign u1 = byte_mode_in ? UNLOCK1_BYTE : UNLOCK1_WORD; // [R18]
  assign u2 = byte_mode_in ? UNLOCK2_BYTE : UNLOCK2_WORD; // [R18]
  assign qry = byte_mode_in ? QUERY_BYTE : QUERY_WORD;
  assign prot_ofs = byte_mode_in ? PROT_OFS_BYTE : PROT_OFS_WORD;
  // only the sector field survives; lower bits are zeroed
  assign sec_addr = {tgt_addr[ADDR_W-1:SECTOR_LSB], SECTOR_LSB'(0)}; // [R4]

  // ======================================================
  // legality of a request against the tracked device mode
  always_comb begin
    case (req_op_in)
      OP_READ: legal = 1'b1; // [R8]
      OP_RESET: legal = !erase_active_out; // [R9]
      OP_PROGRAM: legal = !bypass_mode_out && !erase_active_out; // [R14]
      OP_BYPASS_ENTER: legal = !bypass_mode_out && !id_mode_out && !erase_active_out
                               && !erase_suspended_out;
      OP_BYPASS_PROGRAM, OP_BYPASS_EXIT: legal = bypass_mode_out; // [R12] [R13]
      OP_CHIP_ERASE, OP_SECTOR_ERASE: legal = !bypass_mode_out && !id_mode_out
                               && !erase_active_out && !erase_suspended_out;
      OP_SECTOR_ADD: legal = erase_active_out; // [R17]
      OP_SUSPEND: legal = erase_active_out; // [R15] [R22]
      OP_RESUME: legal = erase_suspended_out && !id_mode_out; // [R16] [R22]
      OP_ID_ENTER: legal = !bypass_mode_out && !erase_active_out && !id_mode_out; // [R14]
      OP_ID_EXIT: legal = id_mode_out;
      OP_QUERY: legal = !bypass_mode_out && !erase_active_out; // [R11]
      OP_PROTECT_VERIFY: legal = !bypass_mode_out && !erase_active_out;
      default: legal = 1'b0;
    endcase
  end
  assign req_ready_out = (st == H_IDLE);
  assign accept = req_valid_in && req_ready_out;

  // ======================================================
  // cycle list for the current op and step
  always_comb begin
    step_write = 1'b1;
    step_addr = ANY_ADDR;
    step_data = D_RESET;
    nsteps = 3'd1;
    case (op)
      OP_READ: begin
        step_write = 1'b0;
        step_addr = tgt_addr;
      end
      OP_RESET: step_data = D_RESET;
      OP_PROGRAM, OP_BYPASS_ENTER, OP_ID_ENTER, OP_ID_EXIT, OP_PROTECT_VERIFY,
      OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
        nsteps = (op == OP_BYPASS_ENTER || op == OP_ID_ENTER) ? 3'd3 :
                 (op == OP_CHIP_ERASE || op == OP_SECTOR_ERASE) ? 3'(MAXSTEP) : 3'd4;
        case (step)
          3'd0: begin step_addr = u1; step_data = D_UNLOCK1; end // [R18]
          3'd1: begin step_addr = u2; step_data = D_UNLOCK2; end
          3'd2: begin
            step_addr = u1;
            case (op)
              OP_PROGRAM: step_data = D_PROGRAM; // [R3]
              OP_BYPASS_ENTER: step_data = D_BYPASS; // [R12]
              OP_ID_ENTER: step_data = D_ID_ENTER; // [R20]
              OP_ID_EXIT, OP_PROTECT_VERIFY: step_data = D_AUTOSELECT; // [R20]
              default: step_data = D_ERASE_SETUP; // [R19]
            endcase
          end
          3'd3: begin
            case (op)
              OP_PROGRAM: step_addr = tgt_addr; // [R3] [R7]
              OP_ID_EXIT: step_data = D_EXIT2; // [R20]
              OP_PROTECT_VERIFY: begin
                step_write = 1'b0; // [R5]
                step_addr = sec_addr | prot_ofs; // [R4]
              end
              default: begin step_addr = u1; step_data = D_UNLOCK1; end // [R19]
            endcase
          end
          3'd4: begin step_addr = u2; step_data = D_UNLOCK2; end
          default: begin
            step_addr = (op == OP_SECTOR_ERASE) ? sec_addr : u1; // [R19] [R4]
            step_data = (op == OP_SECTOR_ERASE) ? D_SECTOR_ERASE : D_CHIP_ERASE;
          end
        endcase
      end
      OP_BYPASS_PROGRAM, OP_BYPASS_EXIT: begin
        nsteps = 3'd2;
        if (step == 3'd0) step_data = (op == OP_BYPASS_PROGRAM) ? D_PROGRAM : D_EXIT1;
        else if (op == OP_BYPASS_PROGRAM) step_addr = tgt_addr; // [R12]
        else step_data = D_EXIT2; // [R13]
      end
      OP_SECTOR_ADD: begin
        step_addr = sec_addr; // [R17]
        step_data = D_SECTOR_ERASE;
      end
      OP_SUSPEND: step_data = D_SUSPEND; // [R15]
      OP_RESUME: step_data = D_RESUME; // [R16]
      OP_QUERY: begin
        step_addr = qry; // [R11]
        step_data = D_QUERY;
      end
      default: step_data = D_RESET;
    endcase
  end

  // the data cycle of a program carries the full word; command cycles
  // drive zeros on the upper byte since the device ignores it
  assign cyc.is_write = step_write;
  assign cyc.addr = step_addr;
  assign cyc.wdata = (step_write && step == nsteps - 3'd1 &&
                      (op == OP_PROGRAM || op == OP_BYPASS_PROGRAM)) ?
                     tgt_data : {8'h00, step_data}; // [R6] [R1] [R2]
  assign cyc.start = (st == H_ISSUE);

  // ======================================================
  // sequencer
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      st <= H_IDLE;
      op <= OP_READ;
      step <= '0;
      tgt_addr <= '0;
      tgt_data <= '0;
    end else begin
      case (st)
        H_IDLE: if (accept && legal) begin
          st <= H_ISSUE;
          op <= req_op_in;
          tgt_addr <= req_addr_in;
          tgt_data <= req_data_in;
          step <= '0;
        end
        H_ISSUE: st <= H_WAIT;
        H_WAIT: if (cyc.done) begin
          if (step == nsteps - 3'd1) st <= H_RESP;
          else begin
            step <= step + 3'd1;
            st <= H_ISSUE;
          end
        end
        H_RESP: st <= H_IDLE;
        default: st <= H_IDLE;
      endcase
    end
  end

  // ======================================================
  // response and refusal
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      resp_valid_out <= 1'b0;
      resp_data_out <= '0;
      req_refused_out <= 1'b0;
    end else begin
      resp_valid_out <= (st == H_WAIT) && cyc.done && (step == nsteps - 3'd1);
      if ((st == H_WAIT) && cyc.done && !step_write)
        resp_data_out <= cyc.rdata; // [R10]
      req_refused_out <= accept && !legal;
    end
  end

  // ======================================================
  // tracked device mode; the device may need up to 35 us to halt, which
  // callers see by polling status reads, not by a wait here
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      bypass_mode_out <= 1'b0;
      id_mode_out <= 1'b0;
      erase_active_out <= 1'b0;
      erase_suspended_out <= 1'b0;
    end else if (st == H_RESP) begin
      case (op)
        OP_BYPASS_ENTER: bypass_mode_out <= 1'b1;
        OP_BYPASS_EXIT: bypass_mode_out <= 1'b0; // [R13]
        OP_SECTOR_ERASE: erase_active_out <= 1'b1;
        OP_SUSPEND: begin
          erase_active_out <= 1'b0; // [R21]
          erase_suspended_out <= 1'b1;
        end
        OP_RESUME: begin
          erase_active_out <= 1'b1; // [R22]
          erase_suspended_out <= 1'b0;
        end
        OP_ID_ENTER, OP_PROTECT_VERIFY: id_mode_out <= 1'b1;
        OP_ID_EXIT: id_mode_out <= 1'b0;
        OP_RESET: begin
          id_mode_out <= 1'b0; // [R9]
          bypass_mode_out <= 1'b0;
        end
        default: id_mode_out <= id_mode_out;
      endcase
    end else if (accept && req_op_in == OP_READ && req_data_in[0]) begin
      // caller reports erase finished (status polled done) via data bit 0
      erase_active_out <= 1'b0;
    end
  end
endmodule : nor_cmd_host
`default_nettype wire

// ### nor_cmd_pkg.sv
// constants and types shared by the flash command sequencer
`default_nettype none
package nor_cmd_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] UNLOCK1_WORD = 20'h00555;
  localparam logic [ADDR_W-1:0] UNLOCK2_WORD = 20'h002AA;
  localparam logic [ADDR_W-1:0] UNLOCK1_BYTE = 20'h00AAA;
  localparam logic [ADDR_W-1:0] UNLOCK2_BYTE = 20'h00555;
  localparam logic [ADDR_W-1:0] QUERY_WORD = 20'h00055;
  localparam logic [ADDR_W-1:0] QUERY_BYTE = 20'h000AA;
  localparam logic [ADDR_W-1:0] ANY_ADDR = 20'h00000;
  localparam logic [ADDR_W-1:0] PROT_OFS_WORD = 20'h00002;
  localparam logic [ADDR_W-1:0] PROT_OFS_BYTE = 20'h00004;
  localparam int SECTOR_LSB = 12;
  localparam logic [7:0] D_UNLOCK1 = 8'hAA;
  localparam logic [7:0] D_UNLOCK2 = 8'h55;
  localparam logic [7:0] D_PROGRAM = 8'hA0;
  localparam logic [7:0] D_BYPASS = 8'h20;
  localparam logic [7:0] D_EXIT1 = 8'h90;
  localparam logic [7:0] D_EXIT2 = 8'h00;
  localparam logic [7:0] D_RESET = 8'hF0;
  localparam logic [7:0] D_ERASE_SETUP = 8'h80;
  localparam logic [7:0] D_CHIP_ERASE = 8'h10;
  localparam logic [7:0] D_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] D_SUSPEND = 8'hB0;
  localparam logic [7:0] D_RESUME = 8'h30;
  localparam logic [7:0] D_ID_ENTER = 8'h88;
  localparam logic [7:0] D_QUERY = 8'h98;
  localparam logic [7:0] D_AUTOSELECT = 8'h90;
  // strobe phase timing in ns, rounded up to clk cycles: setup, low pulse, hold, read access
  localparam int SETUP_NS = 40;
  localparam int PULSE_NS = 80;
  localparam int HOLD_NS = 40;
  localparam int ACCESS_NS = 120;
  localparam int CLK_NS = 40;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 4;
  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_PROGRAM, OP_BYPASS_ENTER, OP_BYPASS_PROGRAM, OP_BYPASS_EXIT,
    OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_SECTOR_ADD, OP_SUSPEND, OP_RESUME, OP_ID_ENTER,
    OP_ID_EXIT, OP_QUERY, OP_PROTECT_VERIFY
  } op_e;
endpackage : nor_cmd_pkg
`default_nettype wire

// ### nor_host_checker.sv
// assertion checker watching the ports of the flash command sequencer
`default_nettype none
// ==========================================
// checker
module nor_host_checker
  import nor_cmd_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  input wire nor_cmd_pkg::op_e req_op_in,
  input wire logic req_refused_out,
  input wire logic bypass_mode_out,
  input wire logic erase_active_out,
  input wire logic erase_suspended_out,
  input wire logic [nor_cmd_pkg::ADDR_W-1:0] flash_addr_out,
  input wire logic flash_ce_n_out,
  input wire logic flash_we_n_out,
  input wire logic flash_oe_n_out,
  input wire logic [nor_cmd_pkg::DATA_W-1:0] flash_dq_out,
  input wire logic flash_dq_oe_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);
  logic take;
  assign take = req_valid_in && req_ready_out;
  property p_wr_no_oe;
    !flash_we_n_out |-> flash_oe_n_out && !flash_ce_n_out;
  endproperty
  a_wr_no_oe: assert property (p_wr_no_oe) else $error("write overlaps read");
  property p_wr_drives;
    !flash_we_n_out |-> flash_dq_oe_out;
  endproperty
  a_wr_drives: assert property (p_wr_drives) else $error("write without data");
  property p_addr_hold;
    !flash_ce_n_out && !$past(flash_ce_n_out) |-> $stable(flash_addr_out);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  property p_data_hold;
    !flash_we_n_out && !$past(flash_we_n_out) |-> $stable(flash_dq_out);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved");
  property p_wr_pulse;
    $fell(flash_we_n_out) |-> !flash_we_n_out [*2] ##[1:2] flash_we_n_out;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("bad write pulse");
  property p_susp_ref;
    take && req_op_in == OP_SUSPEND && !erase_active_out |=> req_refused_out;
  endproperty
  a_susp_ref: assert property (p_susp_ref) else $error("suspend not refused");
  property p_res_ref;
    take && req_op_in == OP_RESUME && !erase_suspended_out |=> req_refused_out;
  endproperty
  a_res_ref: assert property (p_res_ref) else $error("resume not refused");
  property p_query_ref;
    take && req_op_in == OP_QUERY && bypass_mode_out |=> req_refused_out;
  endproperty
  a_query_ref: assert property (p_query_ref) else $error("query not refused");
  property p_ref_quiet;
    req_refused_out |-> flash_ce_n_out [*2];
  endproperty
  a_ref_quiet: assert property (p_ref_quiet) else $error("refused op drove bus");
  c_bypass: cover property ($rose(bypass_mode_out));
  c_susp: cover property ($rose(erase_suspended_out));
  c_ref: cover property (req_refused_out);
endmodule : nor_host_checker
bind nor_cmd_host nor_host_checker i_chk (
  .clk_sys_in, .reset_in, .req_valid_in, .req_ready_out, .req_op_in, .req_refused_out,
  .bypass_mode_out, .erase_active_out, .erase_suspended_out, .flash_addr_out,
  .flash_ce_n_out, .flash_we_n_out, .flash_oe_n_out, .flash_dq_out, .flash_dq_oe_out
);
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the flash command sequencer
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
// ==========================================
// bench
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import nor_cmd_pkg::*;
  localparam logic [7:0] PROT_SEC = 8'h03;
  logic clk_sys_in = 1'b0, reset_in = 1'b1, byte_mode = 1'b0, req_valid = 1'b0;
  op_e req_op = OP_READ;
  logic [ADDR_W-1:0] req_addr = '0, ra;
  logic [DATA_W-1:0] req_data = '0, rv, lfsr = 16'h002E;
  wire logic ready, resp_valid, refused, bypass, id_mode, ce_n, we_n, oe_n, dq_oe;
  wire logic erase_act, erase_susp;
  wire logic [ADDR_W-1:0] f_addr;
  wire logic [DATA_W-1:0] resp_data, f_dq, f_dq_in;
  int n_fail = 0, checks_done = 0, cyc = 0;
  logic [DATA_W-1:0] ref_mem [int];
  bit [255:0] ref_erased;
  nor_cmd_host i_dut (.clk_sys_in, .reset_in, .byte_mode_in(byte_mode),
    .req_valid_in(req_valid), .req_ready_out(ready), .req_op_in(req_op),
    .req_addr_in(req_addr), .req_data_in(req_data), .resp_valid_out(resp_valid),
    .resp_data_out(resp_data), .req_refused_out(refused), .bypass_mode_out(bypass),
    .id_mode_out(id_mode), .erase_active_out(erase_act), .erase_suspended_out(erase_susp),
    .flash_addr_out(f_addr), .flash_ce_n_out(ce_n), .flash_we_n_out(we_n),
    .flash_oe_n_out(oe_n), .flash_dq_out(f_dq), .flash_dq_oe_out(dq_oe),
    .flash_dq_in(f_dq_in));
  flash_model #(.PROT_SECTOR(PROT_SEC)) i_flash (.byte_mode_in(byte_mode), .addr_in(f_addr),
    .ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n), .dq_oe_in(dq_oe), .dq_in(f_dq),
    .dq_out(f_dq_in));
  always #20 clk_sys_in = ~clk_sys_in;
  task automatic print_verdict();
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc >= 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  // random sectors stay below 10h, clear of erase tests
  function automatic void roll();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    ra = {4'h0, lfsr};
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    rv = lfsr;
  endfunction : roll
  function automatic logic [DATA_W-1:0] exp_rd(input logic [ADDR_W-1:0] a);
    if (ref_mem.exists(a)) return ref_mem[a];
    return ref_erased[a[19:12]] ? 16'hFFFF : a[15:0] ^ 16'h5A5A;
  endfunction : exp_rd
  task automatic op(input op_e o, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input bit refuse);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 50) begin
      @(negedge clk_sys_in);
      n++;
    end
    @(posedge clk_sys_in);
    #1;
    req_op = o;
    req_addr = a;
    req_data = d;
    req_valid = 1'b1;
    @(posedge clk_sys_in);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && refused !== 1'b1 && n < 400) begin
      @(negedge clk_sys_in);
      n++;
    end
    `CHK({resp_valid, refused}, {!refuse, refuse})
    @(negedge clk_sys_in);
  endtask : op
  task automatic rd(input logic [ADDR_W-1:0] a);
    op(OP_READ, a, 16'h0000, 1'b0);
    `CHK(resp_data, exp_rd(a))
  endtask : rd
  task automatic prog(input op_e o, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    op(o, a, d, 1'b0);
    ref_mem[a] = d;
  endtask : prog
  initial begin
    repeat (5) @(posedge clk_sys_in);
    #1 reset_in = 1'b0;
    for (int i = 0; i < 3; i++) begin
      roll();
      rd(ra);
    end
    `CHK(i_flash.n_writes, 0)
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_sys_in);
      #1 byte_mode = m[0];
      roll();
      prog(OP_PROGRAM, ra, rv);
      rd(ra);
    end
    op(OP_BYPASS_ENTER, ANY_ADDR, 16'h0000, 1'b0);
    `CHK({bypass, i_flash.bypass}, 2'b11)
    op(OP_QUERY, QUERY_BYTE, 16'h0000, 1'b1);
    for (int i = 0; i < 2; i++) begin
      roll();
      prog(OP_BYPASS_PROGRAM, ra, rv);
      rd(ra);
    end
    op(OP_BYPASS_EXIT, ANY_ADDR, 16'h0000, 1'b0);
    `CHK({bypass, i_flash.bypass}, 2'b00)
    op(OP_BYPASS_ENTER, ANY_ADDR, 16'h0000, 1'b0);
    op(OP_RESET, ANY_ADDR, 16'h0000, 1'b0);
    `CHK({bypass, i_flash.bypass}, 2'b00)
    @(posedge clk_sys_in);
    #1 byte_mode = 1'b0;
    op(OP_SUSPEND, ANY_ADDR, 16'h0000, 1'b1);
    op(OP_RESUME, ANY_ADDR, 16'h0000, 1'b1);
    prog(OP_PROGRAM, 20'h45123, 16'h1234);
    op(OP_SECTOR_ERASE, 20'h45FFF, 16'h0000, 1'b0);
    op(OP_SECTOR_ADD, 20'h46000, 16'h0000, 1'b0);
    ref_mem.delete(20'h45123);
    ref_erased[8'h45] = 1'b1;
    ref_erased[8'h46] = 1'b1;
    op(OP_SUSPEND, ANY_ADDR, 16'h0000, 1'b0);
    `CHK({erase_susp, i_flash.suspended}, 2'b11)
    prog(OP_PROGRAM, 20'h70010, 16'hBEEF);
    rd(20'h70010);
    op(OP_RESUME, ANY_ADDR, 16'h0000, 1'b0);
    `CHK({erase_susp, i_flash.suspended}, 2'b00)
    op(OP_RESUME, ANY_ADDR, 16'h0000, 1'b1);
    op(OP_SUSPEND, ANY_ADDR, 16'h0000, 1'b0);
    op(OP_RESUME, ANY_ADDR, 16'h0000, 1'b0);
    op(OP_READ, 20'h70010, 16'h0001, 1'b0);
    `CHK(erase_act, 1'b0)
    rd(20'h45123);
    rd(20'h46ABC);
    op(OP_CHIP_ERASE, ANY_ADDR, 16'h0000, 1'b0);
    `CHK(i_flash.chip, 1'b1)
    ref_mem.delete();
    ref_erased = '1;
    op(OP_READ, ANY_ADDR, 16'h0001, 1'b0);
    rd(ra);
    op(OP_PROTECT_VERIFY, {PROT_SEC, 12'h000}, 16'h0000, 1'b0);
    `CHK(resp_data, 16'h0001)
    op(OP_QUERY, QUERY_WORD, 16'h0000, 1'b0);
    `CHK(i_flash.query, 1'b1)
    op(OP_RESET, ANY_ADDR, 16'h0000, 1'b0);
    `CHK({id_mode, i_flash.autosel, i_flash.query}, 3'b000)
    op(OP_PROTECT_VERIFY, 20'h05ABC, 16'h0000, 1'b0);
    `CHK(resp_data, 16'h0000)
    op(OP_RESET, ANY_ADDR, 16'h0000, 1'b0);
    op(OP_ID_ENTER, ANY_ADDR, 16'h0000, 1'b0);
    `CHK(i_flash.secured, 1'b1)
    op(OP_ID_EXIT, ANY_ADDR, 16'h0000, 1'b0);
    `CHK(i_flash.secured, 1'b0)
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
